/* File: buck_fault_checker.sv */
`timescale 1ns/1ps
module buck_fault_checker
    import buck_fault_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic pwmRequest,
    input wire logic overcurrentCmp,
    input wire logic vinAboveCmp,
    input wire logic highSideDrive,
    input wire logic cycleStart,
    input wire logic [7:0] outUndervoltThreshold,
    input wire logic [7:0] outOvervoltThreshold,
    input wire logic [4:0] overcurrentThresholdCode
);
    logic [7:0] ocCtrl;
    logic run;
    logic lockEn;
    logic [1:0] skipLeft;
    wire commit = write && !waitrequest;
    wire ocEn = ocCtrl[OC_EN_BIT];
    wire [1:0] blankSel = ocCtrl[6:5];

    // Shadow copies of the control fields.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ocCtrl <= OC_CTRL_RST;
            run <= 1'b0;
            lockEn <= 1'b0;
        end else if (commit) begin
            if (address[5:2] == OFS_OC_CTRL[5:2] && byteenable[0]) ocCtrl <= writedata[7:0];
            if (address[5:2] == OFS_ABE[5:2] && byteenable[0]) run <= writedata[RUN_BIT];
            if (address[5:2] == OFS_LOCKOUT[5:2] && byteenable[1]) lockEn <= writedata[8];
        end
    end

    // Periods left to skip after a drive drop that nothing else explains.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) skipLeft <= 2'h0;
        else if ($fell(highSideDrive) && $past(pwmRequest) && $past(run) && !$past(lockEn))
            skipLeft <= cycleStart ? 2'h1 : 2'h2;
        else if (cycleStart && skipLeft != 2'h0) skipLeft <= skipLeft - 2'h1;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_ACCEPT: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait cycle");
    AST_UNMAPPED: assert property (read && !waitrequest && address[5:2] > 4'h8 |-> readdata == 0)
        else $error("unmapped read returned nonzero data");
    AST_RESET_CODES: assert property ($fell(rst) |-> outOvervoltThreshold == OV_THR_RST &&
        outUndervoltThreshold == UV_THR_RST && overcurrentThresholdCode == OC_CTRL_RST[4:0])
        else $error("threshold codes wrong after reset");
    AST_THR_WRITE: assert property (commit && address[5:2] == 4'h1 && byteenable[0] |=>
        {24'h0, outOvervoltThreshold} == ($past(writedata) & 32'hFF))
        else $error("overvoltage code not taken from write");
    AST_BLANK: assert property ($rose(highSideDrive) ##0 (pwmRequest && run && !lockEn)[*5]
        |=> highSideDrive) else $error("drive cut inside the blanking time");
    AST_OC_CUT: assert property ($rose(highSideDrive) ##0
        (ocEn && blankSel == 2'h0 && overcurrentCmp)[*6] |=> !highSideDrive)
        else $error("overcurrent did not cut the drive");
    AST_OC_OFF: assert property (!ocEn && run && !lockEn && pwmRequest && skipLeft == 2'h0
        |=> highSideDrive) else $error("drive blocked with overcurrent disabled");
    AST_OC_SKIP: assert property (skipLeft != 2'h0 |-> !highSideDrive)
        else $error("drive resumed inside the skipped period");
    AST_LOCKOUT: assert property ((lockEn && !vinAboveCmp)[*4] |-> !highSideDrive)
        else $error("drive on while input is locked out");
    AST_CYCLE: assert property (cycleStart |=> !cycleStart[*8])
        else $error("period start pulses too close");

    cover property (skipLeft == 2'h2);
    cover property (read && !waitrequest && address[5:2] > 4'h8);
    cover property ($rose(highSideDrive) ##0 (ocEn && overcurrentCmp)[*6]);
endmodule // buck_fault_checker

bind buck_fault_protection buck_fault_checker chk (.*);

/* File: buck_fault_pkg.sv */
package buck_fault_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TICK_MHZ = 8;
    localparam logic [5:0] CLK_MHZ_6 = 6'h32;
    localparam logic [5:0] TICK_MHZ_6 = 6'h08;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_UV_THR = 6'h00;
    localparam logic [5:0] OFS_OV_THR = 6'h04;
    localparam logic [5:0] OFS_ABE = 6'h08;
    localparam logic [5:0] OFS_OC_CTRL = 6'h0C;
    localparam logic [5:0] OFS_LOCKOUT = 6'h10;
    localparam logic [5:0] OFS_PERIOD = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1C;
    localparam logic [5:0] OFS_LIVE = 6'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int VP_EN_BIT = 0;
    localparam int RUN_BIT = 1;
    localparam int OC_CODE_LSB = 0;
    localparam int OC_BLANK_LSB = 5;
    localparam int OC_EN_BIT = 7;
    localparam int LOCKOUT_EN_BIT = 8;
    localparam int EVT_UV = 0;
    localparam int EVT_OV = 1;
    localparam int EVT_OC = 2;
    localparam int EVT_LOCKOUT = 3;
    localparam int EVT_COUNT = 4;

    // ------------------------------------------------------------------
    // Reset values and period limits
    // ------------------------------------------------------------------
    localparam logic [7:0] UV_THR_RST = 8'h00;
    localparam logic [7:0] OV_THR_RST = 8'hFF;
    localparam logic [1:0] ABE_RST = 2'h0;
    localparam logic [7:0] OC_CTRL_RST = 8'h1F;
    localparam logic [8:0] LOCKOUT_RST = 9'h000;
    localparam logic [6:0] PERIOD_RST = 7'h14;
    localparam logic [6:0] PERIOD_MIN = 7'h05;
    localparam logic [6:0] PERIOD_MAX = 7'h50;

    // ------------------------------------------------------------------
    // Leading-edge blanking times, least times rounded up to cycles
    // ------------------------------------------------------------------
    localparam int BLANK0_NS = 100;
    localparam int BLANK1_NS = 200;
    localparam int BLANK2_NS = 400;
    localparam int BLANK3_NS = 780;
    localparam int BLANK0_CYC = (BLANK0_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK1_CYC = (BLANK1_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK2_CYC = (BLANK2_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK3_CYC = (BLANK3_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {OC_ARMED, OC_KILL, OC_SKIP} ocState_t;

endpackage

/* File: buck_fault_protection.sv */
`timescale 1ns/1ps
// Contract
// (RQ1) Two threshold codes set the DAC levels for output undervoltage and overvoltage.
// (RQ2) A software control bit switches output voltage protection on or off.
// (RQ3) An output overvoltage or undervoltage event sets an interrupt flag.
// (RQ4) The high-side drop is compared against a 5-bit code and overcurrent is declared above it.
// (RQ5) The overcurrent measurement is ignored during a blanking time chosen by a 2-bit field.
// (RQ6) Overcurrent detection acts only while its enable bit in the same register is set.
// (RQ7) An overcurrent turns the high-side drive off at once and skips the next switching cycle.
// (RQ8) Every overcurrent event sets a flag that firmware can read.
// (RQ9) A lockout code sets the input level above which the converter may turn on.
// (RQ10) The lockout applies only while its enable bit in the same register is set.
// (RQ11) The switching period is a whole number of ticks of an internal 8 MHz time base.
// (RQ12) Blanking starts at each rise of the high-side drive and comparison follows after it.
// (RQ13) Firmware clears each flag after handling it and the flag holds until then; here a status read clears the flags that it returns.
module buck_fault_protection (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic pwmRequest,
    input wire logic outUnderCmp,
    input wire logic outOverCmp,
    input wire logic overcurrentCmp,
    input wire logic vinAboveCmp,
    output logic highSideDrive,
    output logic cycleStart,
    output logic irq,
    output logic [7:0] outUndervoltThreshold,
    output logic [7:0] outOvervoltThreshold,
    output logic [4:0] overcurrentThresholdCode,
    output logic [7:0] lockoutThresholdCode
);
    import buck_fault_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        hit = ({addr[5:2], 2'b00} == ofs);
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        mergeBytes = res;
    endfunction

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [1:0] analogBlockEnableCtrl;
    logic [7:0] overcurrentCtrl;
    logic [8:0] inputLockoutLevel;
    logic [6:0] switchPeriod;
    logic [EVT_COUNT-1:0] irqStatus;
    logic [EVT_COUNT-1:0] irqMask;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire reqActive = read | write;
    wire accept = reqActive & ~waitrequest;
    wire wrAccept = accept & write;
    wire rdStatusAccept = accept & read & hit(address, OFS_IRQ_STATUS);
    wire [31:0] wdUv = mergeBytes({24'h0, outUndervoltThreshold}, writedata, byteenable);
    wire [31:0] wdOv = mergeBytes({24'h0, outOvervoltThreshold}, writedata, byteenable);
    wire [31:0] wdAbe = mergeBytes({30'h0, analogBlockEnableCtrl}, writedata, byteenable);
    wire [31:0] wdOc = mergeBytes({24'h0, overcurrentCtrl}, writedata, byteenable);
    wire [31:0] wdLock = mergeBytes({23'h0, inputLockoutLevel}, writedata, byteenable);
    wire [31:0] wdPer = mergeBytes({25'h0, switchPeriod}, writedata, byteenable);
    wire [31:0] wdMask = mergeBytes({28'h0, irqMask}, writedata, byteenable);

    logic ocSkip;
    logic lockoutActive;
    wire [31:0] liveWord = {29'h0, ocSkip, lockoutActive, highSideDrive};
    wire [31:0] rdMux =
        hit(address, OFS_UV_THR) ? {24'h0, outUndervoltThreshold} :
        hit(address, OFS_OV_THR) ? {24'h0, outOvervoltThreshold} :
        hit(address, OFS_ABE) ? {30'h0, analogBlockEnableCtrl} :
        hit(address, OFS_OC_CTRL) ? {24'h0, overcurrentCtrl} :
        hit(address, OFS_LOCKOUT) ? {23'h0, inputLockoutLevel} :
        hit(address, OFS_PERIOD) ? {25'h0, switchPeriod} :
        hit(address, OFS_IRQ_STATUS) ? {28'h0, irqStatus} :
        hit(address, OFS_IRQ_MASK) ? {28'h0, irqMask} :
        hit(address, OFS_LIVE) ? liveWord :
        32'h0000_0000;

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the access commits
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (reqActive && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= read ? rdMux : 32'h0000_0000;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outUndervoltThreshold <= UV_THR_RST;
            outOvervoltThreshold <= OV_THR_RST;
            analogBlockEnableCtrl <= ABE_RST;
            overcurrentCtrl <= OC_CTRL_RST;
            inputLockoutLevel <= LOCKOUT_RST;
            switchPeriod <= PERIOD_RST;
            irqMask <= '0;
        end else if (wrAccept) begin
            if (hit(address, OFS_UV_THR)) outUndervoltThreshold <= wdUv[7:0]; // RQ1
            if (hit(address, OFS_OV_THR)) outOvervoltThreshold <= wdOv[7:0]; // RQ1
            if (hit(address, OFS_ABE)) analogBlockEnableCtrl <= wdAbe[1:0]; // RQ2
            if (hit(address, OFS_OC_CTRL)) overcurrentCtrl <= wdOc[7:0]; // RQ4 RQ5 RQ6
            if (hit(address, OFS_LOCKOUT)) inputLockoutLevel <= wdLock[8:0]; // RQ9 RQ10
            if (hit(address, OFS_PERIOD)) switchPeriod <= wdPer[6:0];
            if (hit(address, OFS_IRQ_MASK)) irqMask <= wdMask[EVT_COUNT-1:0];
        end
    end

    assign overcurrentThresholdCode = overcurrentCtrl[OC_CODE_LSB +: 5]; // RQ4
    assign lockoutThresholdCode = inputLockoutLevel[7:0]; // RQ9

    // ------------------------------------------------------------------
    // Comparator inputs
    // ------------------------------------------------------------------
    logic [3:0] cmpSync;
    logic [3:0] cmpPrev;

    sync_stage #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({vinAboveCmp, overcurrentCmp, outOverCmp, outUnderCmp}),
        .syncOut(cmpSync)
    );

    wire underSeen = cmpSync[0];
    wire overSeen = cmpSync[1];
    wire ocSeen = cmpSync[2];
    wire vinAbove = cmpSync[3];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmpPrev <= 4'h0;
        end else begin
            cmpPrev <= cmpSync;
        end
    end

    // ------------------------------------------------------------------
    // Switching time base: 8 MHz ticks made from the 50 MHz clock
    // ------------------------------------------------------------------
    // An accumulator keeps the average tick rate exact at one clock of jitter.
    logic [5:0] tickAcc;
    logic [6:0] periodCnt;
    wire [5:0] accSum = tickAcc + TICK_MHZ_6;
    wire tick = (accSum >= CLK_MHZ_6);
    wire [6:0] periodEff = (switchPeriod < PERIOD_MIN) ? PERIOD_MIN :
                           (switchPeriod > PERIOD_MAX) ? PERIOD_MAX : switchPeriod;
    wire periodEnd = tick & (periodCnt >= periodEff - 7'h01);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tickAcc <= 6'h00;
            periodCnt <= 7'h00;
            cycleStart <= 1'b0;
        end else begin
            tickAcc <= tick ? accSum - CLK_MHZ_6 : accSum;
            if (periodEnd) begin
                periodCnt <= 7'h00; // RQ11
            end else if (tick) begin
                periodCnt <= periodCnt + 7'h01;
            end
            cycleStart <= periodEnd; // RQ11
        end
    end

    // ------------------------------------------------------------------
    // Overcurrent and drive gating
    // ------------------------------------------------------------------
    logic ocEvent;
    logic driveBlock;

    overcurrent_guard u_guard (
        .clk_sys(clk_sys),
        .rst(rst),
        .ocEnable(overcurrentCtrl[OC_EN_BIT]),
        .blankSelect(overcurrentCtrl[OC_BLANK_LSB +: 2]),
        .overcurrentSeen(ocSeen),
        .highSideDrive(highSideDrive),
        .cycleStart(cycleStart),
        .ocEvent(ocEvent),
        .driveBlock(driveBlock),
        .skipActive(ocSkip)
    );

    wire lockoutEnable = inputLockoutLevel[LOCKOUT_EN_BIT];
    wire runAllowed = analogBlockEnableCtrl[RUN_BIT] & ~(lockoutEnable & ~vinAbove); // RQ9 RQ10

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            highSideDrive <= 1'b0;
            lockoutActive <= 1'b0;
        end else begin
            highSideDrive <= pwmRequest & runAllowed & ~driveBlock; // RQ7
            lockoutActive <= lockoutEnable & ~vinAbove; // RQ10
        end
    end

    // ------------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------------
    // Only the bits that the read returned are cleared, so an event that
    // lands during the read stays pending.
    wire vpEnable = analogBlockEnableCtrl[VP_EN_BIT];
    wire [EVT_COUNT-1:0] events;
    assign events[EVT_UV] = vpEnable & underSeen & ~cmpPrev[0]; // RQ2 RQ3
    assign events[EVT_OV] = vpEnable & overSeen & ~cmpPrev[1]; // RQ2 RQ3
    assign events[EVT_OC] = ocEvent; // RQ8
    assign events[EVT_LOCKOUT] = lockoutEnable & ~vinAbove & cmpPrev[3];
    wire [EVT_COUNT-1:0] clearMask = rdStatusAccept ? readdata[EVT_COUNT-1:0] : '0;
    wire [EVT_COUNT-1:0] next_irqStatus = (irqStatus & ~clearMask) | events; // RQ13

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqStatus <= '0;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus; // RQ3 RQ8
            irq <= |(next_irqStatus & irqMask);
        end
    end
endmodule // buck_fault_protection

/* File: overcurrent_guard.sv */
`timescale 1ns/1ps
module overcurrent_guard (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ocEnable,
    input wire logic [1:0] blankSelect,
    input wire logic overcurrentSeen,
    input wire logic highSideDrive,
    input wire logic cycleStart,
    output logic ocEvent,
    output logic driveBlock,
    output logic skipActive
);
    import buck_fault_pkg::*;

    function automatic logic [5:0] blankLoad(input logic [1:0] sel);
        unique case (sel)
            2'h0: blankLoad = 6'(BLANK0_CYC - 1);
            2'h1: blankLoad = 6'(BLANK1_CYC - 1);
            2'h2: blankLoad = 6'(BLANK2_CYC - 1);
            2'h3: blankLoad = 6'(BLANK3_CYC - 1);
        endcase
    endfunction

    ocState_t state;
    ocState_t next_state;
    logic drivePrev;
    logic [5:0] blankCnt;
    wire driveRise = highSideDrive & ~drivePrev;
    wire blankDone = (blankCnt == 6'h00) & ~driveRise;

    // The drive rise cycle itself is inside the blanking window.
    assign ocEvent = ocEnable & highSideDrive & blankDone & overcurrentSeen // RQ4 RQ5 RQ6 RQ12
        & (state == OC_ARMED);
    assign driveBlock = ocEvent | (state != OC_ARMED); // RQ7
    assign skipActive = (state == OC_SKIP);

    always_comb begin
        next_state = state;
        unique case (state)
            OC_ARMED: if (ocEvent) next_state = OC_KILL;
            OC_KILL: if (cycleStart) next_state = OC_SKIP; // RQ7
            OC_SKIP: if (cycleStart) next_state = OC_ARMED; // RQ7 RQ11
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= OC_ARMED;
            drivePrev <= 1'b0;
            blankCnt <= 6'h00;
        end else begin
            state <= next_state;
            drivePrev <= highSideDrive;
            if (driveRise) begin
                blankCnt <= blankLoad(blankSelect); // RQ5 RQ12
            end else if (blankCnt != 6'h00) begin
                blankCnt <= blankCnt - 6'h01;
            end
        end
    end
endmodule // overcurrent_guard

/* File: power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
    input wire logic highSideDrive,
    input wire logic [7:0] outUndervoltThreshold,
    input wire logic [7:0] outOvervoltThreshold,
    input wire logic [4:0] overcurrentThresholdCode,
    input wire logic [7:0] lockoutThresholdCode,
    input wire logic [7:0] voutLevel,
    input wire logic [7:0] vinLevel,
    input wire logic [4:0] switchDrop,
    output logic outUnderCmp,
    output logic outOverCmp,
    output logic overcurrentCmp,
    output logic vinAboveCmp
);
    assign outUnderCmp = voutLevel < outUndervoltThreshold;
    assign outOverCmp = voutLevel > outOvervoltThreshold;
    // The switch shows a drop only while it conducts, so the comparator follows the drive.
    assign overcurrentCmp = highSideDrive && (switchDrop > overcurrentThresholdCode);
    assign vinAboveCmp = vinLevel > lockoutThresholdCode;
endmodule // power_stage_model

/* File: sync_stage.sv */
`timescale 1ns/1ps
module sync_stage #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta;

    // Only the second stage is visible outside; the first may be metastable.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            syncOut <= '0;
        end else begin
            meta <= asyncIn;
            syncOut <= meta;
        end
    end
endmodule // sync_stage

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import buck_fault_pkg::*;
    localparam logic [5:0] REGS [8] = '{OFS_UV_THR, OFS_OV_THR, OFS_ABE, OFS_OC_CTRL,
        OFS_LOCKOUT, OFS_PERIOD, OFS_IRQ_MASK, 6'h24};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic pwmRequest = 1'b0;
    logic [7:0] voutLevel = 8'h80;
    logic [7:0] vinLevel = 8'hFF;
    logic [4:0] switchDrop = 5'h00;
    logic [31:0] readdata, rd;
    logic waitrequest, highSideDrive, cycleStart, irq;
    logic outUnderCmp, outOverCmp, overcurrentCmp, vinAboveCmp;
    logic [7:0] outUndervoltThreshold, outOvervoltThreshold, lockoutThresholdCode;
    logic [4:0] overcurrentThresholdCode;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 41964;

    initial forever #10 clk_sys = ~clk_sys;

    buck_fault_protection uut (.*);
    power_stage_model stage (.*);

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk_sys);
            k++;
        end while (waitrequest !== 1'b0 && k < 40);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 40) check("bus answer", 32'h0, 32'h1);
    endtask

    // Park the drive past two periods so the guard is idle before its control changes.
    task automatic setOc(input logic [7:0] v);
        pwmRequest <= 1'b0;
        repeat (80) @(posedge clk_sys);
        access(1'b1, OFS_OC_CTRL, {24'h0, v});
    endtask

    function automatic logic [31:0] resetValue(input logic [5:0] a);
        case (a)
            OFS_OV_THR: return {24'h0, OV_THR_RST};
            OFS_OC_CTRL: return {24'h0, OC_CTRL_RST};
            OFS_PERIOD: return {25'h0, PERIOD_RST};
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] fieldMask(input logic [5:0] a);
        case (a)
            OFS_UV_THR, OFS_OV_THR, OFS_OC_CTRL: return 32'hFF;
            OFS_ABE: return 32'h3;
            OFS_LOCKOUT: return 32'h1FF;
            OFS_PERIOD: return 32'h7F;
            OFS_IRQ_MASK: return 32'hF;
            default: return 32'h0;
        endcase
    endfunction

    function automatic int onTime(input logic [1:0] s);
        return 1 + (s == 2'h0 ? BLANK0_CYC : s == 2'h1 ? BLANK1_CYC :
            s == 2'h2 ? BLANK2_CYC : BLANK3_CYC);
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        miscompares++;
        results();
    end

    initial begin
        logic [31:0] d;
        int n;
        int w;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            access(1'b0, 6'(i * 4), 32'h0);
            check("reset value", rd, resetValue(6'(i * 4)));
        end
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            access(1'b1, REGS[i], d);
            access(1'b0, REGS[i], 32'h0);
            check("readback", rd, d & fieldMask(REGS[i]));
            if (i == 0) check("uv code", {24'h0, outUndervoltThreshold}, d & 32'hFF);
            if (i == 3) check("oc code", {27'h0, overcurrentThresholdCode}, d & 32'h1F);
            if (i == 4) check("lock code", {24'h0, lockoutThresholdCode}, d & 32'hFF);
        end
        access(1'b1, OFS_PERIOD, 32'h5);
        access(1'b1, OFS_LOCKOUT, 32'h0);
        access(1'b1, OFS_UV_THR, 32'h40);
        access(1'b1, OFS_OV_THR, 32'hC0);
        access(1'b1, OFS_IRQ_MASK, 32'hF);
        setOc(8'h1F);
        access(1'b0, OFS_IRQ_STATUS, 32'h0);
        access(1'b0, OFS_IRQ_STATUS, 32'h0);
        check("status idle", rd, 32'h0);
        for (int en = 0; en < 2; en++) for (int e = 0; e < 2; e++) begin
            access(1'b1, OFS_ABE, en ? 32'h3 : 32'h2);
            voutLevel <= e ? 8'hD0 : 8'h30;
            repeat (6) @(posedge clk_sys);
            check("irq", {31'h0, irq}, 32'(en));
            access(1'b0, OFS_IRQ_STATUS, 32'h0);
            check("voltage flag", rd, 32'(en) << e);
            access(1'b0, OFS_IRQ_STATUS, 32'h0);
            check("flag cleared", rd, 32'h0);
            voutLevel <= 8'h80;
            repeat (6) @(posedge clk_sys);
        end
        for (int s = 0; s < 4; s++) begin
            setOc({1'b1, 2'(s), 5'h0A});
            switchDrop <= 5'h0B;
            pwmRequest <= 1'b1;
            n = 0;
            w = 0;
            while (highSideDrive !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                n++;
            end
            while (highSideDrive === 1'b1 && w < 200) begin
                @(posedge clk_sys);
                w++;
            end
            check("on time", 32'(w), 32'(onTime(2'(s))));
            repeat (60) @(posedge clk_sys);
            access(1'b0, OFS_IRQ_STATUS, 32'h0);
            check("overcurrent flag", rd, 32'h4);
        end
        for (int k = 0; k < 2; k++) begin
            switchDrop <= k ? 5'h1F : 5'h0A;
            setOc(k ? 8'h0A : 8'h8A);
            access(1'b0, OFS_IRQ_STATUS, 32'h0);
            pwmRequest <= 1'b1;
            repeat (100) @(posedge clk_sys);
            access(1'b0, OFS_IRQ_STATUS, 32'h0);
            check("no overcurrent", rd, 32'h0);
            check("drive kept", {31'h0, highSideDrive}, 32'h1);
        end
        access(1'b1, OFS_LOCKOUT, 32'h120);
        repeat (6) @(posedge clk_sys);
        check("drive above lockout", {31'h0, highSideDrive}, 32'h1);
        vinLevel <= 8'h10;
        repeat (6) @(posedge clk_sys);
        check("drive locked out", {31'h0, highSideDrive}, 32'h0);
        access(1'b0, OFS_LIVE, 32'h0);
        check("lockout live", rd, 32'h2);
        access(1'b0, OFS_IRQ_STATUS, 32'h0);
        check("lockout flag", rd, 32'h8);
        access(1'b1, OFS_LOCKOUT, 32'h020);
        repeat (6) @(posedge clk_sys);
        check("lockout disabled", {31'h0, highSideDrive}, 32'h1);
        vinLevel <= 8'hFF;
        setOc({1'b1, 2'($random(seed)), 5'h10});
        repeat (400) begin
            @(posedge clk_sys);
            pwmRequest <= 1'($random(seed));
            switchDrop <= 5'($random(seed));
            voutLevel <= 8'($random(seed));
        end
        results();
    end
endmodule // tb
